// ### logic/mch_core.sv
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "mch_map.svh"
//
// Contract
// R1: configuration changes only while a command runs; here host writes also change control words while idle
// R2: select mask bit n picks channel n
// R3: host waits for busy bit clear first
// R4: host loads select mask before code
// R5: host loads filter registers before filter codes
// R6: busy bit clears; nonzero residue means error
// R7: no-op finishes fast with no effect
// R8: thermocouple presets set all channels
// R9: voltage presets set all channels
// R10: filter program copies registers to channels
// R11: filter readback copies channels to registers
// R12: analog filter identifiers land in registers
// R13: sync restarts masked channels from control words
// R14: synced group restarts highest channel first
// R15: any channel combination may be synced
// R16: loop measure takes three seconds, updates masked
// R17: resistance above maximum saturates to all ones
// R18: hard reboot drops off bus then restarts
// R19: soft reset restores power-up values
// R20: full self-test covers every channel
// R21: single self-test takes channel number
// R22: mask self-test covers selected channels
// R23: device reports status through command register
// R24: unknown code leaves nonzero residue, no effect
module mch_core #(
   parameter logic SELFTEST = 1'b1,
   parameter logic [35:0] RES_CYC = `MCH_MS2CYC(`MCH_T_RES_MS),
   parameter logic [35:0] HARD_CYC = `MCH_MS2CYC(`MCH_T_HARD_MS),
   parameter logic [35:0] ST_ALL_CYC = `MCH_MS2CYC(`MCH_T_ST_ALL_MS),
   parameter logic [35:0] ST_ONE_CYC = `MCH_MS2CYC(`MCH_T_ST_ONE_MS),
   parameter logic [35:0] ST_MASK_CYC = `MCH_MS2CYC(`MCH_T_ST_MASK_MS)
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [15:0] result_valid,
   input wire logic [15:0][17:0] meas_res,
   input wire logic [15:0][15:0] afilt_id,
   input wire logic selftest_fault,
   output logic [15:0][15:0] chan_ctl,
   output logic [15:0][15:0] dfilt_cfg,
   output logic [15:0] chan_restart,
   output logic res_meas_run,
   output logic selftest_run,
   output logic [15:0] selftest_mask,
   output logic bus_offline
);
   mch_pkg::mch_core_t s, next_s;
   mch_pkg::mch_req_t req; // write strobe from the bus port
   logic [7:0] rd_idx; // index of the pending read
   logic [15:0] rd_data; // word selected for that read
   logic seq_start; // kick the restart scanner
   logic seq_done; // scanner walked all channels
   logic ctl_may; // control words may legally move next edge
   logic res_fin; // measurement finishing this cycle

   // power-up contents of every register
   function automatic mch_pkg::mch_core_t core_rst();
      mch_pkg::mch_core_t r;
      r = '0;
      r.st = mch_pkg::ST_IDLE;
      for (int i = 0; i < 16; i++) begin
         r.ctl[i] = `MCH_CTL_RESET;
         r.res[i] = `MCH_RES_RESET;
         r.filt[i] = `MCH_FILT_RESET;
         r.dfilt[i] = `MCH_FILT_RESET;
      end
      return r;
   endfunction

   // codes this build accepts
   function automatic logic op_known(input logic [15:0] op);
      logic k;
      k = 1'b0;
      unique case (op)
         `MCH_OP_NOP, `MCH_OP_TC_J, `MCH_OP_TC_K, `MCH_OP_TC_E,
         `MCH_OP_TC_T, `MCH_OP_V12, `MCH_OP_V80M, `MCH_OP_V25M,
         `MCH_OP_FPROG, `MCH_OP_FREAD, `MCH_OP_AFID, `MCH_OP_SYNC,
         `MCH_OP_RES, `MCH_OP_HARD, `MCH_OP_SOFT: k = 1'b1;
         `MCH_OP_ST_ALL, `MCH_OP_ST_ONE, `MCH_OP_ST_MASK: k = SELFTEST;
         default: k = 1'b0;
      endcase
      return k;
   endfunction

   // bus front end
   mch_ahb_port u_port (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .rd_data(rd_data),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .rd_idx(rd_idx),
      .req(req)
   );

   // restart scanner for synchronisation
   mch_desc_seq u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(seq_start),
      .mask(s.param),
      .pulse(chan_restart),
      .done(seq_done)
   );

   assign chan_ctl = s.ctl;
   assign dfilt_cfg = s.dfilt;
   assign res_meas_run = s.meas;
   assign selftest_run = s.st_run;
   assign selftest_mask = s.tmask;
   assign bus_offline = s.offline;
   assign seq_start = (s.st == mch_pkg::ST_EXEC) && (s.op == `MCH_OP_SYNC);
   assign res_fin = (s.st == mch_pkg::ST_WAIT) && s.meas
      && (s.timer == 36'h0_0000_0000);
   // a finishing hard reboot reloads the power-up words as well
   assign ctl_may = (s.st == mch_pkg::ST_EXEC)
      || ((s.st == mch_pkg::ST_WAIT) && s.offline)
      || ((s.st == mch_pkg::ST_IDLE) && req.wr);

   // read multiplexer; a rebooting board answers zero
   always_comb begin
      rd_data = 16'h0000;
      if (!s.offline) begin
         if (rd_idx == `MCH_IDX_MACRO) begin
            rd_data = s.macro;
         end else if (rd_idx == `MCH_IDX_PARAM) begin
            rd_data = s.param;
         end else if (rd_idx[7:4] == `MCH_IDX_CTL >> 4) begin
            rd_data = s.ctl[rd_idx[3:0]];
         end else if (rd_idx[7:4] == `MCH_IDX_UPC >> 4) begin
            rd_data = s.upc[rd_idx[3:0]];
         end else if (rd_idx[7:4] == `MCH_IDX_RES >> 4) begin
            rd_data = s.res[rd_idx[3:0]];
         end else if (rd_idx[7:4] == `MCH_IDX_FILT >> 4) begin
            rd_data = s.filt[rd_idx[3:0]];
         end
      end
   end

   // command engine next state
   always_comb begin
      next_s = s;
      // result counters belong to the device and always run
      for (int i = 0; i < 16; i++) begin
         if (result_valid[i]) begin
            next_s.upc[i] = s.upc[i] + 16'h0001;
         end
      end
      unique case (s.st)
         mch_pkg::ST_IDLE: begin
            // host writes land only while no command owns the map
            if (req.wr) begin
               if (req.idx == `MCH_IDX_MACRO) begin
                  next_s.macro = req.data;
                  if (req.data[`MCH_BUSY_BIT]) begin
                     next_s.op = req.data;
                     next_s.st = mch_pkg::ST_EXEC;
                  end
               end else if (req.idx == `MCH_IDX_PARAM) begin
                  next_s.param = req.data;
               end else if (req.idx[7:4] == `MCH_IDX_CTL >> 4) begin
                  next_s.ctl[req.idx[3:0]] = req.data;
               end else if (req.idx[7:4] == `MCH_IDX_RES >> 4) begin
                  next_s.res[req.idx[3:0]] = req.data;
               end else if (req.idx[7:4] == `MCH_IDX_FILT >> 4) begin
                  next_s.filt[req.idx[3:0]] = req.data;
               end
            end
         end
         mch_pkg::ST_EXEC: begin
            // most commands finish here; busy clears with no residue
            next_s.macro = 16'h0000; // see R6, R23
            next_s.st = mch_pkg::ST_IDLE;
            unique case (s.op)
               `MCH_OP_NOP: begin
                  // nothing but the handshake itself
                  next_s.macro = 16'h0000; // see R7
               end
               `MCH_OP_TC_J, `MCH_OP_TC_K, `MCH_OP_TC_E, `MCH_OP_TC_T,
               `MCH_OP_V12, `MCH_OP_V80M, `MCH_OP_V25M: begin
                  for (int i = 0; i < 16; i++) begin
                     unique case (s.op)
                        `MCH_OP_TC_J: next_s.ctl[i] = `MCH_CTL_TC_J; // see R8
                        `MCH_OP_TC_K: next_s.ctl[i] = `MCH_CTL_TC_K;
                        `MCH_OP_TC_E: next_s.ctl[i] = `MCH_CTL_TC_E;
                        `MCH_OP_TC_T: next_s.ctl[i] = `MCH_CTL_TC_T;
                        `MCH_OP_V12: next_s.ctl[i] = `MCH_CTL_V12; // see R9
                        `MCH_OP_V80M: next_s.ctl[i] = `MCH_CTL_V80M;
                        default: next_s.ctl[i] = `MCH_CTL_V25M;
                     endcase
                  end
               end
               `MCH_OP_FPROG: begin
                  next_s.dfilt = s.filt; // see R10, R1
               end
               `MCH_OP_FREAD: begin
                  next_s.filt = s.dfilt; // see R11
               end
               `MCH_OP_AFID: begin
                  next_s.filt = afilt_id; // see R12
               end
               `MCH_OP_SYNC: begin
                  // scanner restarts masked channels from their words
                  next_s.macro = s.macro; // see R13, R15
                  next_s.st = mch_pkg::ST_SEQ;
               end
               `MCH_OP_RES: begin
                  // one shared interval, whatever the mask holds
                  next_s.macro = s.macro;
                  next_s.meas = 1'b1; // see R16
                  next_s.timer = RES_CYC - 36'h0_0000_0002;
                  next_s.st = mch_pkg::ST_WAIT;
               end
               `MCH_OP_HARD: begin
                  next_s.macro = s.macro;
                  next_s.offline = 1'b1; // see R18
                  next_s.timer = HARD_CYC - 36'h0_0000_0002;
                  next_s.st = mch_pkg::ST_WAIT;
               end
               `MCH_OP_SOFT: begin
                  next_s = core_rst(); // see R19
               end
               `MCH_OP_ST_ALL, `MCH_OP_ST_ONE, `MCH_OP_ST_MASK: begin
                  next_s.macro = s.macro;
                  next_s.st_run = 1'b1;
                  next_s.st = mch_pkg::ST_WAIT;
                  if (!SELFTEST) begin
                     // plain variant refuses the self-test codes
                     next_s.macro = s.op & `MCH_ERR_MASK; // see R24
                     next_s.st_run = 1'b0;
                     next_s.st = mch_pkg::ST_IDLE;
                  end else if (s.op == `MCH_OP_ST_ALL) begin
                     next_s.tmask = 16'hffff; // see R20
                     next_s.timer = ST_ALL_CYC - 36'h0_0000_0002;
                  end else if (s.op == `MCH_OP_ST_MASK) begin
                     next_s.tmask = s.param; // see R22, R2
                     next_s.timer = ST_MASK_CYC - 36'h0_0000_0002;
                  end else if (s.param[15:4] != 12'h000) begin
                     // a channel number above 15 is an error
                     next_s.macro = s.op & `MCH_ERR_MASK; // see R21
                     next_s.st_run = 1'b0;
                     next_s.st = mch_pkg::ST_IDLE;
                  end else begin
                     next_s.tmask = 16'h0001 << s.param[3:0]; // see R21
                     next_s.timer = ST_ONE_CYC - 36'h0_0000_0002;
                  end
               end
               default: begin
                  // unknown code: no effect, residue flags the error
                  next_s.macro = s.op & `MCH_ERR_MASK; // see R24
               end
            endcase
         end
         mch_pkg::ST_SEQ: begin
            if (seq_done) begin
               next_s.macro = 16'h0000; // see R6
               next_s.st = mch_pkg::ST_IDLE;
            end
         end
         mch_pkg::ST_WAIT: begin
            if (s.timer != 36'h0_0000_0000) begin
               next_s.timer = s.timer - 36'h0_0000_0001;
            end else if (s.offline) begin
               // reboot over: back on the bus with fresh contents
               next_s = core_rst(); // see R18
               next_s.upc = '0;
            end else begin
               next_s.macro = 16'h0000; // see R6
               next_s.st = mch_pkg::ST_IDLE;
               next_s.meas = 1'b0;
               next_s.st_run = 1'b0;
               next_s.tmask = '0;
               if (s.st_run && selftest_fault) begin
                  next_s.macro = s.op & `MCH_ERR_MASK; // see R6
               end
               if (s.meas) begin
                  for (int i = 0; i < 16; i++) begin
                     // only the masked channels get a new value
                     if (s.param[i]) begin // see R2, R16
                        next_s.res[i] = (meas_res[i] > 18'h0_ffff)
                           ? `MCH_RES_MAX : meas_res[i][15:0]; // see R17
                     end
                  end
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= core_rst();
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   busy_bit_a: assert property (s.st != mch_pkg::ST_IDLE
      |-> s.macro[`MCH_BUSY_BIT]) // see R6
      else $error("busy bit clear while a command runs");
   ctl_owner_a: assert property (s.ctl != $past(s.ctl)
      |-> $past(ctl_may)) // see R1
      else $error("control words moved without a command or write");
   nop_quiet_a: assert property (s.st == mch_pkg::ST_EXEC
      && s.op == `MCH_OP_NOP |=> s.macro == 16'h0000
      && s.ctl == $past(s.ctl) && s.filt == $past(s.filt)) // see R7
      else $error("no-op left residue or changed state");
   preset_j_a: assert property (s.st == mch_pkg::ST_EXEC
      && s.op == `MCH_OP_TC_J |=> s.ctl[0] == `MCH_CTL_TC_J
      && s.ctl[15] == `MCH_CTL_TC_J && s.macro == 16'h0000) // see R8
      else $error("type J preset not applied to all channels");
   sync_time_a: assert property (seq_start
      |-> ##[17:18] s.st == mch_pkg::ST_IDLE && s.macro == 16'h0000) // see R13
      else $error("synchronisation did not finish on time");
   res_sat_a: assert property (res_fin && s.param[0]
      && meas_res[0] > 18'h0_ffff |=> s.res[0] == `MCH_RES_MAX) // see R17
      else $error("oversize loop resistance not saturated");
   bad_code_a: assert property (s.st == mch_pkg::ST_EXEC && !op_known(s.op)
      |=> s.macro != 16'h0000 && !s.macro[`MCH_BUSY_BIT]
      && s.ctl == $past(s.ctl)) // see R24
      else $error("unknown code did not report an error");
   soft_rst_a: assert property (s.st == mch_pkg::ST_EXEC
      && s.op == `MCH_OP_SOFT |=> s.macro == 16'h0000
      && s.upc[0] == 16'h0000 && s.res[0] == `MCH_RES_RESET) // see R19
      else $error("soft reset did not restore power-up values");
   offline_read_a: assert property (s.offline |-> rd_data == 16'h0000) // see R18
      else $error("register visible while rebooting");

   sync_done_c: cover property (seq_start ##[17:18] s.st == mch_pkg::ST_IDLE);
   res_done_c: cover property (res_fin ##1 s.st == mch_pkg::ST_IDLE);
   error_c: cover property (s.st == mch_pkg::ST_EXEC && !op_known(s.op));
   reboot_c: cover property (s.offline ##1 !s.offline);
endmodule

// ### logic/mch_map.svh
`ifndef MCH_MAP_SVH
`define MCH_MAP_SVH
// register indices; byte address is four times the index
`define MCH_IDX_MACRO 8'h10
`define MCH_IDX_PARAM 8'h11
`define MCH_IDX_CTL 8'h50
`define MCH_IDX_UPC 8'h60
`define MCH_IDX_RES 8'h70
`define MCH_IDX_FILT 8'h80
// top bit of the command register means busy
`define MCH_BUSY_BIT 15
// residue mask left behind on a failed command
`define MCH_ERR_MASK 16'h7fff
// command codes
`define MCH_OP_NOP 16'h8400
`define MCH_OP_TC_J 16'h8401
`define MCH_OP_TC_K 16'h8402
`define MCH_OP_TC_E 16'h8403
`define MCH_OP_TC_T 16'h8404
`define MCH_OP_V12 16'h8405
`define MCH_OP_V80M 16'h8406
`define MCH_OP_V25M 16'h8407
`define MCH_OP_FPROG 16'h8408
`define MCH_OP_FREAD 16'h8409
`define MCH_OP_AFID 16'h840b
`define MCH_OP_SYNC 16'h840c
`define MCH_OP_ST_ALL 16'h8410
`define MCH_OP_ST_ONE 16'h8411
`define MCH_OP_ST_MASK 16'h8412
`define MCH_OP_RES 16'h8418
`define MCH_OP_HARD 16'h8420
`define MCH_OP_SOFT 16'h8421
// channel control words loaded by the preset commands
`define MCH_CTL_TC_J 16'h0021
`define MCH_CTL_TC_K 16'h0022
`define MCH_CTL_TC_E 16'h0023
`define MCH_CTL_TC_T 16'h0024
`define MCH_CTL_V12 16'h0001
`define MCH_CTL_V80M 16'h0002
`define MCH_CTL_V25M 16'h0003
// power-up values
`define MCH_CTL_RESET 16'h0000
`define MCH_RES_RESET 16'h0000
`define MCH_FILT_RESET 16'h0000
// saturated loop resistance, quarter ohms
`define MCH_RES_MAX 16'hffff
// highest channel number
`define MCH_CH_TOP 4'hf
// clock rate and task times
`define MCH_CLK_KHZ 125000
`define MCH_T_RES_MS 3000
`define MCH_T_HARD_MS 4000
`define MCH_T_ST_ALL_MS 80000
`define MCH_T_ST_ONE_MS 50000
`define MCH_T_ST_MASK_MS 80000
`define MCH_MS2CYC(ms) (36'(ms) * 36'(`MCH_CLK_KHZ))
`endif

// ### logic/mch_pkg.sv
package mch_pkg;
   // command engine states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SEQ,
      ST_WAIT
   } mch_state_t;
   // one register write from the bus port
   typedef struct packed {
      logic wr;
      logic [7:0] idx;
      logic [15:0] data;
   } mch_req_t;
   // bus port state
   typedef struct packed {
      logic pend;
      logic wr;
      logic ok;
      logic [7:0] idx;
      logic [31:0] rdata;
      logic ready;
      logic resp;
   } mch_port_t;
   // descending restart scanner state
   typedef struct packed {
      logic [15:0] mask;
      logic [3:0] ch;
      logic busy;
      logic done;
      logic [15:0] pulse;
   } mch_seq_t;
   // command engine state
   typedef struct packed {
      mch_state_t st;
      logic [15:0] macro;
      logic [15:0] param;
      logic [15:0] op;
      logic [15:0][15:0] ctl;
      logic [15:0][15:0] res;
      logic [15:0][15:0] filt;
      logic [15:0][15:0] dfilt;
      logic [15:0][15:0] upc;
      logic [35:0] timer;
      logic offline;
      logic meas;
      logic st_run;
      logic [15:0] tmask;
   } mch_core_t;
endpackage

// ### logic/mch_ahb_port.sv
`timescale 1ns/1ps
`include "mch_map.svh"
// ahb-lite slave front end: one wait state on every transfer
module mch_ahb_port (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [15:0] rd_data,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [7:0] rd_idx,
   output mch_pkg::mch_req_t req
);
   mch_pkg::mch_port_t s, next_s;
   logic accept; // address phase taken this edge
   // only whole-word singles arrive, so hsize is not decoded
   assign accept = hsel & htrans[1] & hready;
   assign rd_idx = s.idx;
   assign hrdata = s.rdata;
   assign hreadyout = s.ready;
   assign hresp = s.resp;
   // writes commit in the first data cycle, when hwdata stands
   assign req.wr = s.pend & s.wr & s.ok;
   assign req.idx = s.idx;
   assign req.data = hwdata[15:0];
   // next state of the port
   always_comb begin
      next_s = s;
      next_s.resp = 1'b0;
      if (accept) begin
         next_s.pend = 1'b1;
         next_s.wr = hwrite;
         next_s.idx = haddr[9:2];
         // anything beyond the 256-word window is unmapped
         next_s.ok = (haddr[31:10] == 22'h00_0000);
         next_s.ready = 1'b0;
      end else if (s.pend) begin
         next_s.pend = 1'b0;
         next_s.ready = 1'b1;
         // unmapped reads and all writes return zero
         next_s.rdata = (s.ok && !s.wr) ? {16'h0000, rd_data} : '0;
      end
   end
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{ready: 1'b1, default: '0};
      end else begin
         s <= next_s;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wait_state_a: assert property (accept |=> !hreadyout ##1 hreadyout)
      else $error("transfer did not take exactly one wait state");
endmodule

// ### logic/mch_desc_seq.sv
`timescale 1ns/1ps
`include "mch_map.svh"
// steps through one channel per cycle, channel 15 first, restarting only the masked ones
module mch_desc_seq (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic [15:0] mask,
   output logic [15:0] pulse,
   output logic done
);
   mch_pkg::mch_seq_t s, next_s;
   assign pulse = s.pulse;
   assign done = s.done;
   // scan from the top channel down to zero
   always_comb begin
      next_s = s;
      next_s.pulse = '0;
      next_s.done = 1'b0;
      if (start) begin
         next_s.mask = mask;
         next_s.ch = `MCH_CH_TOP;
         next_s.busy = 1'b1;
      end else if (s.busy) begin
         // the fixed walk keeps low channels restarting last
         next_s.pulse[s.ch] = s.mask[s.ch]; // see R14
         if (s.ch == 4'h0) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end else begin
            next_s.ch = s.ch - 4'h1;
         end
      end
   end
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   scan_down_a: assert property (s.busy && s.ch != 4'h0 && !start
      |=> s.ch == $past(s.ch) - 4'h1) // see R14
      else $error("restart scan did not step downward");
   pulse_mask_a: assert property (pulse != '0
      |-> $onehot(pulse) && (pulse & ~s.mask) == '0) // see R15
      else $error("restart pulse outside the selected mask");
endmodule

// ### test/mch_front_model.sv
`timescale 1ns/1ps
// acquisition front end behind the block: fixed readings, echoed results
module mch_front_model (
   input wire logic hclk,
   input wire logic [15:0] chan_restart,
   input wire logic fault_in,
   output logic [15:0] result_valid,
   output logic [15:0][17:0] meas_res,
   output logic [15:0][15:0] afilt_id,
   output logic selftest_fault
);
   // a restarted channel reports one fresh result a cycle later
   always @(posedge hclk) result_valid <= chan_restart;
   // ch0 reads above full scale, so the block has to clip it
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         meas_res[i] = 18'(i * 4 + 1);
         afilt_id[i] = 16'h00a0 + 16'(i);
      end
      meas_res[0] = 18'h3_ffff;
   end
   // self-test verdict is steered by the bench
   assign selftest_fault = fault_in;
endmodule

// ### test/test_macro_command_handshake.sv
`timescale 1ns/1ps
module test_macro_command_handshake;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
   logic hreadyout, hresp, res_meas_run, selftest_run, bus_offline;
   logic [15:0] result_valid, chan_restart, selftest_mask;
   logic [15:0][17:0] meas_res;
   logic [15:0][15:0] afilt_id, chan_ctl, dfilt_cfg;
   logic selftest_fault, off_seen = 1'b0;
   logic st_bad = 1'b0, meas_seen = 1'b0;
   logic [15:0] tm_last = '0;
   logic [2:0] hsize = '0;
   logic [15:0] seen[$];
   int n_fail = 0, n_checks = 0;
   mch_core #(.RES_CYC(36'h14), .HARD_CYC(36'h14), .ST_ALL_CYC(36'h14),
      .ST_ONE_CYC(36'h14), .ST_MASK_CYC(36'h14)) dut (.hclk, .hresetn,
      .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .result_valid,
      .meas_res, .afilt_id, .selftest_fault, .chan_ctl, .dfilt_cfg,
      .chan_restart, .res_meas_run, .selftest_run, .selftest_mask,
      .bus_offline);
   mch_front_model far (.hclk, .chan_restart, .fault_in(st_bad),
      .result_valid, .meas_res, .afilt_id, .selftest_fault);
   initial forever #4 hclk = ~hclk;
   // log pulses and run flags mid-cycle, clear of the launching edge
   always @(negedge hclk) begin
      if (chan_restart !== 16'h0000) seen.push_back(chan_restart);
      if (bus_offline) off_seen <= 1'b1;
      if (res_meas_run) meas_seen <= 1'b1;
      if (selftest_run) tm_last <= selftest_mask;
   end
   function automatic logic [31:0] ra(input logic [7:0] i);
      return {22'h0, i, 2'b00};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // one single ahb transfer, begun just after a rising edge; hready
   // is judged mid-cycle, as the next rising edge will sample it
   task automatic xfer(input logic w, input logic [31:0] a,
                       input logic [15:0] d);
      hsel <= 1'b1; htrans <= 2'b10; haddr <= a; hwrite <= w;
      hsize <= 3'h2;
      do @(negedge hclk); while (hreadyout !== 1'b1);
      @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= {16'h0000, d};
      do @(negedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      @(posedge hclk);
   endtask
   task automatic rd(input logic [7:0] i, input logic [15:0] e);
      xfer(1'b0, ra(i), 16'h0000);
      chk(q, {16'h0000, e});
   endtask
   // parameter first, then code, then poll until the busy bit drops
   task automatic cmd(input logic [15:0] code, input logic [15:0] p);
      int n;
      xfer(1'b1, ra(8'h11), p);
      xfer(1'b1, ra(8'h10), code);
      n = 0;
      do begin
         xfer(1'b0, ra(8'h10), 16'h0000);
         n++;
      end while (q[15] !== 1'b0 && n < 400);
      chk({31'h0, q[15]}, 32'h0);
   endtask
   task automatic t_sync();
      int j = 0;
      cmd(16'h840c, 16'h8421);
      chk(q, 32'h0);
      for (int i = 15; i >= 0; i--) if (i[0] | 1) begin
         if (16'h8421 & (16'h0001 << i)) begin
            chk({16'h0, seen[j]}, 32'h1 << i);
            j++;
         end
      end
      rd(8'h60, 16'h0001);
      rd(8'h61, 16'h0000);
      cmd(16'h840c, 16'h0002);
      chk(32'(seen.size()), 32'h5);
   endtask
   task automatic t_nop();
      xfer(1'b1, ra(8'h55), 16'h1234);
      cmd(16'h8400, 16'h0000);
      chk(q, 32'h0);
      rd(8'h55, 16'h1234);
      rd(8'hff, 16'h0000);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic t_preset();
      logic [15:0] cw[7] = '{16'h0021, 16'h0022, 16'h0023, 16'h0024,
                             16'h0001, 16'h0002, 16'h0003};
      for (int i = 0; i < 7; i++) begin
         cmd(16'h8401 + 16'(i), 16'h0000);
         chk({chan_ctl[15], chan_ctl[0]}, {cw[i], cw[i]});
      end
      rd(8'h57, 16'h0003);
   endtask
   task automatic t_filt();
      xfer(1'b1, ra(8'h83), 16'h0055);
      cmd(16'h8408, 16'h0000);
      chk({16'h0, dfilt_cfg[3]}, 32'h55);
      xfer(1'b1, ra(8'h83), 16'h0000);
      cmd(16'h8409, 16'h0000);
      rd(8'h83, 16'h0055);
      cmd(16'h840b, 16'hffff);
      rd(8'h82, 16'h00a2);
   endtask
   task automatic t_res();
      cmd(16'h8418, 16'h0003);
      chk({31'h0, meas_seen}, 32'h1);
      rd(8'h70, 16'hffff);
      rd(8'h71, 16'h0005);
      rd(8'h72, 16'h0000);
   endtask
   task automatic t_err();
      cmd(16'h8455, 16'h0000);
      chk(q, 32'h0455);
      cmd(16'h8411, 16'h0010);
      chk(q, 32'h0411);
      cmd(16'h8411, 16'h0005);
      chk(q, 32'h0);
      chk({16'h0, tm_last}, 32'h0020);
      cmd(16'h8410, 16'h0000);
      chk(q, 32'h0);
      chk({16'h0, tm_last}, 32'hffff);
      cmd(16'h8412, 16'h00f0);
      chk(q, 32'h0);
      chk({16'h0, tm_last}, 32'h00f0);
      // a failing self-test must leave the code's residue behind
      st_bad <= 1'b1;
      cmd(16'h8410, 16'h0000);
      chk(q, 32'h0410);
      st_bad <= 1'b0;
   endtask
   task automatic t_boot();
      cmd(16'h8421, 16'h0000);
      rd(8'h50, 16'h0000);
      cmd(16'h8401, 16'h0000);
      cmd(16'h8420, 16'h0000);
      for (int n = 0; n < 200 && !(off_seen && !bus_offline); n++)
         @(posedge hclk);
      chk({31'h0, off_seen}, 32'h1);
      rd(8'h50, 16'h0000);
   endtask
   task automatic print_verdict();
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // a hang counts as a failure
   initial begin
      #200_000;
      n_fail++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_sync();
      t_nop();
      t_preset();
      t_filt();
      t_res();
      t_err();
      t_boot();
      print_verdict();
   end
endmodule
